// *** src/ebp_pkg.sv ***
// Shared constants and types for the external bus and port A block.
package ebp_pkg;

  // Register offsets on the plain register port.
  localparam logic [15:0] OFS_PA_DATA = 16'h0000;
  localparam logic [15:0] OFS_PB_DATA = 16'h0001;
  localparam logic [15:0] OFS_PA_DIR = 16'h0002;
  localparam logic [15:0] OFS_PB_DIR = 16'h0003;
  localparam logic [15:0] OFS_PE_DATA = 16'h0008;
  localparam logic [15:0] OFS_PE_DIR = 16'h0009;
  localparam logic [15:0] OFS_MISC = 16'h0013;
  localparam logic [15:0] OFS_CTRL = 16'h0020;
  localparam logic [15:0] OFS_STAT = 16'h0021;

  // Offsets below this bound leave the map in peripheral mode.
  localparam logic [15:0] MAP_REMOVED_TOP = 16'h0010;

  // Field positions.
  localparam int MISC_NARROW_FOLLOW_MAP_BUS_POS = 6;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_EME_POS = 2;
  localparam int STAT_RW_POS = 0;
  localparam int STAT_A0_POS = 1;
  localparam int STAT_STRB_POS = 2;
  localparam int STAT_BUSY_POS = 3;

  // Reset values.
  localparam logic [7:0] PA_DATA_RST = 8'h00;
  localparam logic [7:0] PA_DIR_RST = 8'h00;
  localparam logic NARROW_FOLLOW_MAP_BUS_RST = 1'b0;
  localparam logic EME_RST = 1'b0;

  // Upper six address bits of the 1K register-following window.
  localparam logic [5:0] FOLLOW_PAGE = 6'h01;

  // Bus phase timing, in ns, and the derived cycle counts (least times round up).
  localparam int CLK_PERIOD_NS = 10;
  localparam int ADDR_PHASE_NS = 20;
  localparam int DATA_PHASE_NS = 40;
  localparam int ADDR_CYC = (ADDR_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DATA_CYC = (DATA_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Operating modes.
  typedef enum logic [1:0] {
    EBP_MODE_SINGLE = 2'b00,
    EBP_MODE_EXP_NARROW = 2'b01,
    EBP_MODE_EXP_WIDE = 2'b10,
    EBP_MODE_PERIPH = 2'b11
  } ebp_mode_e;

  // Bus cycle states, Gray coded along idle, address, data.
  typedef enum logic [1:0] {
    EBP_ST_IDLE = 2'b00,
    EBP_ST_ADDR = 2'b01,
    EBP_ST_DATA = 2'b11
  } ebp_state_e;

endpackage : ebp_pkg

// *** src/ebp_top.sv ***
// External multiplexed bus sequencer and port A register block.
`timescale 1ns/1ps
`default_nettype none

module ebp_top #(
  parameter int ADDR_CYCLES = ebp_pkg::ADDR_CYC,
  parameter int DATA_CYCLES = ebp_pkg::DATA_CYC,
  parameter logic [5:0] FOLLOW_PAGE = ebp_pkg::FOLLOW_PAGE
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Register port.
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_offmap,
  // Core access port.
  input wire logic acc_valid,
  input wire logic [15:0] acc_addr,
  input wire logic acc_write,
  input wire logic acc_word,
  input wire logic acc_ram,
  input wire logic [15:0] acc_wdata,
  output logic acc_ready,
  output logic acc_done,
  output logic [15:0] acc_rdata,
  // Bus control pins.
  output logic e_bus_clock,
  output logic bus_rw,
  output logic bus_a0,
  output logic low_byte_strobe_n,
  // Port A and port B pins.
  input wire logic [7:0] port_a_pin_in,
  output logic [7:0] port_a_pin_out,
  output logic [7:0] port_a_pin_oe,
  input wire logic [7:0] port_b_pin_in,
  output logic [7:0] port_b_pin_out,
  output logic [7:0] port_b_pin_oe
);

  localparam logic [3:0] ADDR_LOAD = 4'(ADDR_CYCLES - 1);
  localparam logic [3:0] DATA_LOAD = 4'(DATA_CYCLES - 1);

  // Register state.
  logic [7:0] pa_data_reg, pa_data_next;
  logic [7:0] pa_dir_reg, pa_dir_next;
  logic narrow_follow_map_bus_reg, narrow_follow_map_bus_next;
  logic eme_reg, eme_next;
  ebp_pkg::ebp_mode_e mode_reg, mode_next;
  logic [7:0] rdata_reg, rdata_next;
  logic offmap_reg, offmap_next;

  // Pin synchronisers and filtered levels.
  logic [7:0] pa_s1_reg, pa_s2_reg, pa_s3_reg, pa_in_reg, pa_in_next;
  logic [7:0] pb_s1_reg, pb_s2_reg, pb_s3_reg, pb_in_reg, pb_in_next;
  logic [7:0] pa_rd_val;

  // Bus cycle state.
  ebp_pkg::ebp_state_e st_reg, st_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [15:0] cyc_addr_reg, cyc_addr_next;
  logic cyc_write_reg, cyc_write_next;
  logic cyc_word_reg, cyc_word_next;
  logic cyc_narrow_reg, cyc_narrow_next;
  logic [7:0] cyc_b0_reg, cyc_b0_next;
  logic [7:0] cyc_b1_reg, cyc_b1_next;
  logic split_reg, split_next;
  logic second_reg, second_next;
  logic [7:0] rd_hi_reg, rd_hi_next;
  logic [15:0] acc_rdata_reg, acc_rdata_next;
  logic acc_done_reg, acc_done_next;
  logic acc_ready_reg, acc_ready_next;
  logic e_reg, e_next;
  logic rw_reg, rw_next;
  logic a0_reg, a0_next;
  logic strb_n_reg, strb_n_next;
  logic [7:0] pa_out_reg, pa_out_next, pa_oe_reg, pa_oe_next;
  logic [7:0] pb_out_reg, pb_out_next, pb_oe_reg, pb_oe_next;

  logic reg_off;
  logic narrow_go;
  logic split_go;
  logic [7:0] rb0;
  logic [7:0] rb1;

  // Per-bit input filtering and port A read value.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      assign pa_in_next[gi] = (pa_s2_reg[gi] == pa_s3_reg[gi]) ? pa_s3_reg[gi] : pa_in_reg[gi];
      assign pb_in_next[gi] = (pb_s2_reg[gi] == pb_s3_reg[gi]) ? pb_s3_reg[gi] : pb_in_reg[gi];
      assign pa_rd_val[gi] = pa_dir_reg[gi] ? pa_data_reg[gi] : pa_in_reg[gi];
    end
  endgenerate

  // Synchronisers; the first stage feeds only the second.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pa_s1_reg <= 8'h00;
      pa_s2_reg <= 8'h00;
      pa_s3_reg <= 8'h00;
      pa_in_reg <= 8'h00;
      pb_s1_reg <= 8'h00;
      pb_s2_reg <= 8'h00;
      pb_s3_reg <= 8'h00;
      pb_in_reg <= 8'h00;
    end else begin
      pa_s1_reg <= port_a_pin_in;
      pa_s2_reg <= pa_s1_reg;
      pa_s3_reg <= pa_s2_reg;
      pa_in_reg <= pa_in_next;
      pb_s1_reg <= port_b_pin_in;
      pb_s2_reg <= pb_s1_reg;
      pb_s3_reg <= pb_s2_reg;
      pb_in_reg <= pb_in_next;
    end
  end

  // Map decode, register writes and the one-cycle read answer.
  always_comb begin
    pa_data_next = pa_data_reg;
    pa_dir_next = pa_dir_reg;
    narrow_follow_map_bus_next = narrow_follow_map_bus_reg;
    eme_next = eme_reg;
    mode_next = mode_reg;
    rdata_next = 8'h00;
    reg_off = 1'b0;
    if (mode_reg == ebp_pkg::EBP_MODE_PERIPH && reg_addr < ebp_pkg::MAP_REMOVED_TOP) begin
      reg_off = 1'b1;
    end
    if (mode_reg != ebp_pkg::EBP_MODE_SINGLE &&
        (reg_addr == ebp_pkg::OFS_PA_DATA || reg_addr == ebp_pkg::OFS_PB_DATA ||
         reg_addr == ebp_pkg::OFS_PA_DIR || reg_addr == ebp_pkg::OFS_PB_DIR)) begin
      reg_off = 1'b1;
    end
    if ((mode_reg == ebp_pkg::EBP_MODE_EXP_NARROW || mode_reg == ebp_pkg::EBP_MODE_EXP_WIDE) &&
        eme_reg && (reg_addr == ebp_pkg::OFS_PE_DATA || reg_addr == ebp_pkg::OFS_PE_DIR)) begin
      reg_off = 1'b1;
    end
    offmap_next = (reg_wr | reg_rd) & reg_off;
    if (reg_wr && !reg_off) begin
      case (reg_addr)
        ebp_pkg::OFS_PA_DATA: pa_data_next = reg_wdata;
        ebp_pkg::OFS_PA_DIR: pa_dir_next = reg_wdata;
        ebp_pkg::OFS_MISC: narrow_follow_map_bus_next = reg_wdata[ebp_pkg::MISC_NARROW_FOLLOW_MAP_BUS_POS];
        ebp_pkg::OFS_CTRL: begin
          mode_next = ebp_pkg::ebp_mode_e'(reg_wdata[ebp_pkg::CTRL_MODE_LSB +: 2]);
          eme_next = reg_wdata[ebp_pkg::CTRL_EME_POS];
        end
        default: ;
      endcase
    end
    if (reg_rd && !reg_off) begin
      case (reg_addr)
        ebp_pkg::OFS_PA_DATA: rdata_next = pa_rd_val;
        ebp_pkg::OFS_PA_DIR: rdata_next = pa_dir_reg;
        ebp_pkg::OFS_MISC: rdata_next[ebp_pkg::MISC_NARROW_FOLLOW_MAP_BUS_POS] = narrow_follow_map_bus_reg;
        ebp_pkg::OFS_CTRL: begin
          rdata_next[ebp_pkg::CTRL_MODE_LSB +: 2] = mode_reg;
          rdata_next[ebp_pkg::CTRL_EME_POS] = eme_reg;
        end
        ebp_pkg::OFS_STAT: begin
          rdata_next[ebp_pkg::STAT_RW_POS] = rw_reg;
          rdata_next[ebp_pkg::STAT_A0_POS] = a0_reg;
          rdata_next[ebp_pkg::STAT_STRB_POS] = strb_n_reg;
          rdata_next[ebp_pkg::STAT_BUSY_POS] = (st_reg != ebp_pkg::EBP_ST_IDLE);
        end
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // Register file flip-flops.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pa_data_reg <= ebp_pkg::PA_DATA_RST;
      pa_dir_reg <= ebp_pkg::PA_DIR_RST;
      narrow_follow_map_bus_reg <= ebp_pkg::NARROW_FOLLOW_MAP_BUS_RST;
      eme_reg <= ebp_pkg::EME_RST;
      mode_reg <= ebp_pkg::EBP_MODE_SINGLE;
      rdata_reg <= 8'h00;
      offmap_reg <= 1'b0;
    end else begin
      pa_data_reg <= pa_data_next;
      pa_dir_reg <= pa_dir_next;
      narrow_follow_map_bus_reg <= narrow_follow_map_bus_next;
      eme_reg <= eme_next;
      mode_reg <= mode_next;
      rdata_reg <= rdata_next;
      offmap_reg <= offmap_next;
    end
  end

  // Read lanes: the byte at the cycle address and the byte after it.
  assign rb0 = (!cyc_narrow_reg && cyc_addr_reg[0]) ? pb_in_reg : pa_in_reg;
  assign rb1 = cyc_addr_reg[0] ? pa_in_reg : pb_in_reg;

  // Follow-window width choice and word splitting at launch.
  assign narrow_go = (mode_reg == ebp_pkg::EBP_MODE_EXP_NARROW) ||
                     (mode_reg == ebp_pkg::EBP_MODE_EXP_WIDE && narrow_follow_map_bus_reg &&
                      acc_addr[15:10] == FOLLOW_PAGE);
  assign split_go = acc_word && (narrow_go || (acc_addr[0] && !acc_ram));

  // Bus cycle sequencer and pin drive.
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    cyc_addr_next = cyc_addr_reg;
    cyc_write_next = cyc_write_reg;
    cyc_word_next = cyc_word_reg;
    cyc_narrow_next = cyc_narrow_reg;
    cyc_b0_next = cyc_b0_reg;
    cyc_b1_next = cyc_b1_reg;
    split_next = split_reg;
    second_next = second_reg;
    rd_hi_next = rd_hi_reg;
    acc_rdata_next = acc_rdata_reg;
    acc_done_next = 1'b0;
    case (st_reg)
      ebp_pkg::EBP_ST_IDLE: begin
        if (acc_valid && acc_ready_reg) begin
          cyc_addr_next = acc_addr;
          cyc_write_next = acc_write;
          cyc_word_next = acc_word && !split_go;
          cyc_narrow_next = narrow_go;
          cyc_b0_next = acc_word ? acc_wdata[15:8] : acc_wdata[7:0];
          cyc_b1_next = acc_wdata[7:0];
          split_next = split_go;
          second_next = 1'b0;
          st_next = ebp_pkg::EBP_ST_ADDR;
          cnt_next = ADDR_LOAD;
        end
      end
      ebp_pkg::EBP_ST_ADDR: begin
        if (cnt_reg == 4'h0) begin
          st_next = ebp_pkg::EBP_ST_DATA;
          cnt_next = DATA_LOAD;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      ebp_pkg::EBP_ST_DATA: begin
        if (cnt_reg != 4'h0) begin
          cnt_next = cnt_reg - 4'h1;
        end else if (split_reg) begin
          rd_hi_next = rb0;
          split_next = 1'b0;
          second_next = 1'b1;
          cyc_addr_next = cyc_addr_reg + 16'h0001;
          cyc_b0_next = cyc_b1_reg;
          st_next = ebp_pkg::EBP_ST_ADDR;
          cnt_next = ADDR_LOAD;
        end else begin
          acc_done_next = 1'b1;
          second_next = 1'b0;
          if (second_reg) begin
            acc_rdata_next = {rd_hi_reg, rb0};
          end else if (cyc_word_reg) begin
            acc_rdata_next = {rb0, rb1};
          end else begin
            acc_rdata_next = {8'h00, rb0};
          end
          st_next = ebp_pkg::EBP_ST_IDLE;
        end
      end
      default: st_next = ebp_pkg::EBP_ST_IDLE;
    endcase
    acc_ready_next = (st_next == ebp_pkg::EBP_ST_IDLE) && (mode_next != ebp_pkg::EBP_MODE_SINGLE);
    // Bus control levels follow the cycle that the sequencer enters.
    e_next = (st_next == ebp_pkg::EBP_ST_DATA);
    rw_next = !((st_next != ebp_pkg::EBP_ST_IDLE) && cyc_write_next);
    a0_next = (st_next != ebp_pkg::EBP_ST_IDLE) && cyc_addr_next[0];
    strb_n_next = 1'b1;
    if (st_next != ebp_pkg::EBP_ST_IDLE) begin
      strb_n_next = cyc_word_next ? cyc_addr_next[0] : !cyc_addr_next[0];
    end
    pa_out_next = 8'h00;
    pa_oe_next = 8'h00;
    pb_out_next = 8'h00;
    pb_oe_next = 8'h00;
    if (mode_next == ebp_pkg::EBP_MODE_SINGLE) begin
      pa_out_next = pa_data_reg;
      pa_oe_next = pa_dir_reg;
    end else if (st_next == ebp_pkg::EBP_ST_ADDR) begin
      pa_out_next = cyc_addr_next[15:8];
      pb_out_next = cyc_addr_next[7:0];
      pa_oe_next = 8'hff;
      pb_oe_next = 8'hff;
    end else if (st_next == ebp_pkg::EBP_ST_DATA) begin
      if (cyc_narrow_next) begin
        pb_out_next = cyc_addr_next[7:0];
        pb_oe_next = 8'hff;
      end
      if (cyc_write_next) begin
        if (cyc_narrow_next) begin
          pa_out_next = cyc_b0_next;
          pa_oe_next = 8'hff;
        end else if (cyc_word_next) begin
          pa_out_next = cyc_addr_next[0] ? cyc_b1_next : cyc_b0_next;
          pb_out_next = cyc_addr_next[0] ? cyc_b0_next : cyc_b1_next;
          pa_oe_next = 8'hff;
          pb_oe_next = 8'hff;
        end else if (cyc_addr_next[0]) begin
          pb_out_next = cyc_b0_next;
          pb_oe_next = 8'hff;
        end else begin
          pa_out_next = cyc_b0_next;
          pa_oe_next = 8'hff;
        end
      end
    end
  end

  // Bus cycle flip-flops.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= ebp_pkg::EBP_ST_IDLE;
      cnt_reg <= 4'h0;
      cyc_addr_reg <= 16'h0000;
      cyc_write_reg <= 1'b0;
      cyc_word_reg <= 1'b0;
      cyc_narrow_reg <= 1'b0;
      cyc_b0_reg <= 8'h00;
      cyc_b1_reg <= 8'h00;
      split_reg <= 1'b0;
      second_reg <= 1'b0;
      rd_hi_reg <= 8'h00;
      acc_rdata_reg <= 16'h0000;
      acc_done_reg <= 1'b0;
      acc_ready_reg <= 1'b0;
      e_reg <= 1'b0;
      rw_reg <= 1'b1;
      a0_reg <= 1'b0;
      strb_n_reg <= 1'b1;
      pa_out_reg <= 8'h00;
      pa_oe_reg <= 8'h00;
      pb_out_reg <= 8'h00;
      pb_oe_reg <= 8'h00;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      cyc_addr_reg <= cyc_addr_next;
      cyc_write_reg <= cyc_write_next;
      cyc_word_reg <= cyc_word_next;
      cyc_narrow_reg <= cyc_narrow_next;
      cyc_b0_reg <= cyc_b0_next;
      cyc_b1_reg <= cyc_b1_next;
      split_reg <= split_next;
      second_reg <= second_next;
      rd_hi_reg <= rd_hi_next;
      acc_rdata_reg <= acc_rdata_next;
      acc_done_reg <= acc_done_next;
      acc_ready_reg <= acc_ready_next;
      e_reg <= e_next;
      rw_reg <= rw_next;
      a0_reg <= a0_next;
      strb_n_reg <= strb_n_next;
      pa_out_reg <= pa_out_next;
      pa_oe_reg <= pa_oe_next;
      pb_out_reg <= pb_out_next;
      pb_oe_reg <= pb_oe_next;
    end
  end

  // Outputs come straight from flip-flops.
  assign reg_rdata = rdata_reg;
  assign reg_offmap = offmap_reg;
  assign acc_ready = acc_ready_reg;
  assign acc_done = acc_done_reg;
  assign acc_rdata = acc_rdata_reg;
  assign e_bus_clock = e_reg;
  assign bus_rw = rw_reg;
  assign bus_a0 = a0_reg;
  assign low_byte_strobe_n = strb_n_reg;
  assign port_a_pin_out = pa_out_reg;
  assign port_a_pin_oe = pa_oe_reg;
  assign port_b_pin_out = pb_out_reg;
  assign port_b_pin_oe = pb_oe_reg;

endmodule : ebp_top

`default_nettype wire

// *** tb/ebp_chk.sv ***
// Assertion checker for the external bus and port A block.
`timescale 1ns/1ps
`default_nettype none
module ebp_chk #(
  parameter int ADDR_CYCLES = 2,
  parameter int DATA_CYCLES = 4
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Register port.
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_offmap,
  // Access port.
  input wire logic acc_valid,
  input wire logic [15:0] acc_addr,
  input wire logic acc_write,
  input wire logic acc_word,
  input wire logic acc_ram,
  input wire logic acc_ready,
  input wire logic acc_done,
  // Bus pins.
  input wire logic e_bus_clock,
  input wire logic bus_rw,
  input wire logic bus_a0,
  input wire logic low_byte_strobe_n,
  input wire logic [7:0] port_a_pin_out,
  input wire logic [7:0] port_a_pin_oe
);
  localparam int BYTE_LAT = ADDR_CYCLES + DATA_CYCLES + 1;
  logic [7:0] hi_reg;
  logic word_reg, ram_reg, wr_reg, a0_reg;

  // Keeps the attributes of the access in flight, since the pins alone cannot tell them.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      {hi_reg, word_reg, ram_reg, wr_reg, a0_reg} <= 12'h000;
    end else if (acc_valid && acc_ready) begin
      {hi_reg, word_reg, ram_reg, wr_reg, a0_reg} <=
        {acc_addr[15:8], acc_word, acc_ram, acc_write, acc_addr[0]};
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_take;
    acc_valid && acc_ready;
  endsequence
  sequence s_addr_out;
    port_a_pin_oe == 8'hff && port_a_pin_out == hi_reg;
  endsequence

  a_idle_pins: assert property (acc_ready |-> low_byte_strobe_n && bus_rw && !bus_a0 && !e_bus_clock)
    else $error("bus pins not idle while ready");
  a_ram_only: assert property (e_bus_clock && low_byte_strobe_n && bus_a0 |-> ram_reg && word_reg)
    else $error("strobe and a0 both high outside a ram word");
  a_rw_dir: assert property (e_bus_clock |-> bus_rw == !wr_reg)
    else $error("read/write line does not match access");
  a_byte_code: assert property (e_bus_clock && !word_reg |->
    low_byte_strobe_n != a0_reg && bus_a0 == a0_reg)
    else $error("byte cycle strobe or a0 wrong");
  a_word_even: assert property (e_bus_clock && !low_byte_strobe_n && !bus_a0 |-> word_reg && !a0_reg)
    else $error("even word code on another access");
  a_addr_phase: assert property (s_take |=> s_addr_out)
    else $error("port A does not carry high address");
  a_read_release: assert property (e_bus_clock && bus_rw |-> port_a_pin_oe == 8'h00)
    else $error("port A driven during read data");
  a_byte_time: assert property (s_take ##0 !acc_word |-> ##BYTE_LAT acc_done)
    else $error("byte access not done on time");
  a_offmap_cause: assert property (reg_offmap |-> $past(reg_rd || reg_wr))
    else $error("offmap pulse without strobe");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside answer cycle");
endmodule : ebp_chk

bind ebp_top ebp_chk #(.ADDR_CYCLES(ADDR_CYCLES), .DATA_CYCLES(DATA_CYCLES)) u_chk (
  .clk, .sys_rst, .reg_wr, .reg_rd, .reg_rdata, .reg_offmap, .acc_valid, .acc_addr,
  .acc_write, .acc_word, .acc_ram, .acc_ready, .acc_done, .e_bus_clock, .bus_rw,
  .bus_a0, .low_byte_strobe_n, .port_a_pin_out, .port_a_pin_oe);
`default_nettype wire

// *** tb/ebp_ext_mem.sv ***
// External memory on the multiplexed bus, also resolving the port A and B wires.
`timescale 1ns/1ps
`default_nettype none
module ebp_ext_mem (
  // Clock.
  input wire logic clk,
  // Bus pins from the block.
  input wire logic e_bus_clock,
  input wire logic bus_rw,
  input wire logic bus_a0,
  input wire logic low_byte_strobe_n,
  input wire logic [7:0] port_a_pin_out,
  input wire logic [7:0] port_a_pin_oe,
  input wire logic [7:0] port_b_pin_out,
  input wire logic [7:0] port_b_pin_oe,
  // Wiring and behaviour controls.
  input wire logic narrow,
  input wire logic slow,
  input wire logic [7:0] gpio_val,
  input wire logic gpio_en,
  // Resolved pin levels.
  output logic [7:0] port_a_pin_in,
  output logic [7:0] port_b_pin_in
);
  logic [7:0] mem [0:255];
  logic [7:0] adr_reg, a_idx, b_idx, pa_last, pb_last;
  logic e_reg, a_use, b_use, drv;

  // Memory starts cleared so reads of untouched bytes are defined.
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'h00;
    end
  end

  // Lane choice from strobe and a0; narrow wiring keeps everything on port A.
  always_comb begin
    a_use = 1'b1;
    b_use = 1'b0;
    a_idx = adr_reg;
    b_idx = adr_reg + 8'h01;
    if (!narrow) begin
      case ({low_byte_strobe_n, bus_a0})
        2'b00: b_use = 1'b1;
        2'b01: begin
          a_use = 1'b0;
          b_use = 1'b1;
          b_idx = adr_reg;
        end
        2'b11: begin
          b_use = 1'b1;
          b_idx = adr_reg;
          a_idx = adr_reg + 8'h01;
        end
        default: a_use = 1'b1;
      endcase
    end
    drv = e_bus_clock && bus_rw && (e_reg || !slow);
    // Undriven lines show the inverse of their last level; port A shows gpio_val instead while gpio_en is set.
    port_a_pin_in = (port_a_pin_oe & port_a_pin_out) | (~port_a_pin_oe &
      ((drv && a_use) ? mem[a_idx] : (gpio_en ? gpio_val : ~pa_last)));
    port_b_pin_in = (port_b_pin_oe & port_b_pin_out) | (~port_b_pin_oe &
      ((drv && b_use) ? mem[b_idx] : ~pb_last));
  end

  // Latches the low address and stores written lanes.
  always_ff @(posedge clk) begin
    e_reg <= e_bus_clock;
    pa_last <= port_a_pin_in;
    pb_last <= port_b_pin_in;
    if (!e_bus_clock && port_a_pin_oe == 8'hff && port_b_pin_oe == 8'hff) begin
      adr_reg <= port_b_pin_out;
    end
    if (e_bus_clock && !bus_rw) begin
      if (a_use) begin
        mem[a_idx] <= port_a_pin_out;
      end
      if (b_use) begin
        mem[b_idx] <= port_b_pin_out;
      end
    end
  end
endmodule : ebp_ext_mem
`default_nettype wire

// *** tb/test_ebp_top.sv ***
// Self-checking bench for the external bus and port A block.
`timescale 1ns/1ps
`default_nettype none
module test_ebp_top;
  // Block inputs and bench controls.
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic acc_valid = 1'b0;
  logic [15:0] acc_addr = 16'h0000;
  logic acc_write = 1'b0;
  logic acc_word = 1'b0;
  logic acc_ram = 1'b0;
  logic [15:0] acc_wdata = 16'h0000;
  logic narrow = 1'b0;
  logic slow = 1'b0;
  logic [7:0] gpio_val = 8'h30;
  logic gpio_en = 1'b1;
  // Block outputs.
  logic [7:0] reg_rdata, port_a_pin_in, port_a_pin_out, port_a_pin_oe;
  logic [7:0] port_b_pin_in, port_b_pin_out, port_b_pin_oe;
  logic [15:0] acc_rdata;
  logic reg_offmap, acc_ready, acc_done, e_bus_clock, bus_rw, bus_a0, low_byte_strobe_n;
  int err_total = 0;
  int n_checks = 0;

  // Six data cycles let the slow partner's data clear the pin filter just in the last data cycle, with none to spare.
  ebp_top #(.DATA_CYCLES(6)) uut (
    .clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_offmap,
    .acc_valid, .acc_addr, .acc_write, .acc_word, .acc_ram, .acc_wdata, .acc_ready,
    .acc_done, .acc_rdata, .e_bus_clock, .bus_rw, .bus_a0, .low_byte_strobe_n,
    .port_a_pin_in, .port_a_pin_out, .port_a_pin_oe, .port_b_pin_in, .port_b_pin_out,
    .port_b_pin_oe);

  ebp_ext_mem u_mem (
    .clk, .e_bus_clock, .bus_rw, .bus_a0, .low_byte_strobe_n, .port_a_pin_out,
    .port_a_pin_oe, .port_b_pin_out, .port_b_pin_oe, .narrow, .slow, .gpio_val,
    .gpio_en, .port_a_pin_in, .port_b_pin_in);

  // Free-running 100 MHz clock.
  initial begin
    forever #5 clk = ~clk;
  end

  // Compares one value and reports a mismatch at once.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Prints the verdict and ends the run.
  task automatic report_and_stop();
    if (err_total == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  // One register write, strobe released one edge later.
  task automatic reg_write(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  // One register read; data and offmap flag are judged in the answer cycle.
  task automatic reg_read(input logic [15:0] a, input logic [7:0] d, input logic off);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    check({8'h00, reg_rdata}, {8'h00, d});
    check({15'h0000, reg_offmap}, {15'h0000, off});
  endtask : reg_read

  // One core access; pins {strobe, a0, rw} are judged in the first data cycle.
  task automatic bus_access(input logic [15:0] a, input logic wr, input logic wd_word,
                            input logic ram, input logic [15:0] wd, input logic [2:0] pins,
                            input logic [15:0] rd);
    int cnt;
    cnt = 0;
    @(posedge clk);
    while (acc_ready !== 1'b1 && cnt < 50) begin
      @(posedge clk);
      cnt++;
    end
    acc_valid <= 1'b1;
    acc_addr <= a;
    acc_write <= wr;
    acc_word <= wd_word;
    acc_ram <= ram;
    acc_wdata <= wd;
    @(posedge clk);
    acc_valid <= 1'b0;
    while (e_bus_clock !== 1'b1 && cnt < 100) begin
      @(posedge clk);
      cnt++;
    end
    check({13'h0000, low_byte_strobe_n, bus_a0, bus_rw}, {13'h0000, pins});
    while (acc_done !== 1'b1 && cnt < 200) begin
      @(posedge clk);
      cnt++;
    end
    check({15'h0000, acc_done}, 16'h0001);
    if (!wr) begin
      check(acc_rdata, rd);
    end
  endtask : bus_access

  // Main sequence.
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    reg_read(ebp_pkg::OFS_PA_DIR, 8'h00, 1'b0);
    check({15'h0000, acc_ready}, 16'h0000);
    reg_write(ebp_pkg::OFS_PA_DIR, 8'h0f);
    reg_write(ebp_pkg::OFS_PA_DATA, 8'ha5);
    repeat (4) @(posedge clk);
    check({8'h00, port_a_pin_oe}, 16'h000f);
    check({12'h000, port_a_pin_out[3:0]}, 16'h0005);
    reg_read(ebp_pkg::OFS_PA_DATA, 8'h35, 1'b0);
    gpio_en <= 1'b0;
    reg_write(ebp_pkg::OFS_CTRL, 8'h02);
    reg_read(ebp_pkg::OFS_PA_DATA, 8'h00, 1'b1);
    reg_read(ebp_pkg::OFS_PA_DIR, 8'h00, 1'b1);
    reg_read(ebp_pkg::OFS_PB_DATA, 8'h00, 1'b1);
    reg_read(ebp_pkg::OFS_PE_DATA, 8'h00, 1'b0);
    reg_read(16'h0050, 8'h00, 1'b0);
    reg_write(ebp_pkg::OFS_CTRL, 8'h06);
    reg_read(ebp_pkg::OFS_CTRL, 8'h06, 1'b0);
    reg_read(ebp_pkg::OFS_PE_DIR, 8'h00, 1'b1);
    reg_write(ebp_pkg::OFS_CTRL, 8'h02);
    // Wide bus: every strobe and a0 code, then read back.
    bus_access(16'h0010, 1'b1, 1'b1, 1'b0, 16'h1122, 3'b000, 16'h0000);
    bus_access(16'h0011, 1'b0, 1'b0, 1'b0, 16'h0000, 3'b011, 16'h0022);
    bus_access(16'h0012, 1'b1, 1'b0, 1'b0, 16'h0033, 3'b100, 16'h0000);
    bus_access(16'h0013, 1'b1, 1'b0, 1'b0, 16'h0044, 3'b010, 16'h0000);
    slow <= 1'b1;
    bus_access(16'h0012, 1'b0, 1'b1, 1'b0, 16'h0000, 3'b001, 16'h3344);
    bus_access(16'h0021, 1'b1, 1'b1, 1'b1, 16'h5566, 3'b110, 16'h0000);
    bus_access(16'h0021, 1'b0, 1'b1, 1'b1, 16'h0000, 3'b111, 16'h5566);
    bus_access(16'h0011, 1'b0, 1'b1, 1'b0, 16'h0000, 3'b011, 16'h2233);
    // Narrow bus splits words onto port A.
    reg_write(ebp_pkg::OFS_CTRL, 8'h01);
    narrow <= 1'b1;
    bus_access(16'h0030, 1'b1, 1'b1, 1'b0, 16'h7788, 3'b100, 16'h0000);
    bus_access(16'h0030, 1'b0, 1'b1, 1'b0, 16'h0000, 3'b101, 16'h7788);
    // With the bit set, only the follow window goes narrow.
    reg_write(ebp_pkg::OFS_CTRL, 8'h02);
    reg_write(ebp_pkg::OFS_MISC, 8'h40);
    bus_access(16'h0402, 1'b1, 1'b1, 1'b0, 16'h8899, 3'b100, 16'h0000);
    bus_access(16'h0402, 1'b0, 1'b1, 1'b0, 16'h0000, 3'b101, 16'h8899);
    narrow <= 1'b0;
    bus_access(16'h0010, 1'b0, 1'b1, 1'b0, 16'h0000, 3'b001, 16'h1122);
    reg_read(ebp_pkg::OFS_STAT, 8'h05, 1'b0);
    // Peripheral mode drops the low sixteen offsets only.
    reg_write(ebp_pkg::OFS_CTRL, 8'h03);
    reg_read(ebp_pkg::OFS_PA_DIR, 8'h00, 1'b1);
    reg_read(ebp_pkg::OFS_MISC, 8'h40, 1'b0);
    report_and_stop();
  end

  // Cuts a hang short well after the expected run length.
  initial begin
    #200000;
    err_total++;
    report_and_stop();
  end
endmodule : test_ebp_top
`default_nettype wire
